//--- rcf_map.svh
// Register map and field positions for the reset cause flag block
`ifndef RCF_MAP_SVH
`define RCF_MAP_SVH
`define RCF_REG_ADDR 8'hF2
`define RCF_REG_BANK 1'h1
`define RCF_BIT_LVR 1
`define RCF_BIT_WDT 2
`define RCF_BIT_PIN 4
`define RCF_OPT_LVR_EN 7
`define RCF_OPT_PIN_RST 2
`define RCF_FLAG_MASK 8'h16
`define RCF_LVR_ONLY 8'h02
`define RCF_RDATA_RST 8'h00
`endif

//--- rcf_pkg.sv
// Types shared by the reset cause flag block
package rcf_pkg;
    // Register access from the core, direct or indirect register addressing
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bank;
        logic       direct;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcf_access_t;
    // Reset event pulses
    typedef struct packed {
        logic low_voltage_reset;
        logic watchdog_timer;
        logic external_reset_pin;
    } rcf_events_t;
endpackage

//--- rcf_flags.sv
// Reset cause flag register; low voltage flag sticks until a write, watchdog and pin flags stick until a write or a low voltage reset
`timescale 1ns/10ps
`default_nettype none
`include "rcf_map.svh"
module rcf_flags
    import rcf_pkg::*;
(
    input wire logic core_clk_i,          // CPU clock
    input wire logic rst_i,               // Sync reset, flags ignore it
    input wire rcf_access_t acc_i,        // Register access
    input wire rcf_events_t evt_i,        // Reset event pulses
    input wire logic [7:0] boot_opt_i,    // Boot option byte
    output logic [7:0] rdata_o,           // Read data
    output logic lvr_flag_valid_o,        // Bit 1 meaningful
    output logic pin_flag_valid_o         // Bit 4 meaningful
);
    // Only bits 1, 2 and 4 hold state; the rest read and stay 0
    localparam logic [7:0] LIVE_MASK = `RCF_FLAG_MASK;

    logic [7:0] flags = 8'h00; // Initial value only for simulation
    logic [7:0] next_flags;
    logic [7:0] set_vec;
    logic dir_ok;
    logic bank_ok;
    logic addr_ok;
    logic hit;
    logic wr_hit;
    logic rd_hit;

    // Decode pieces kept apart so each miss case is easy to see
    assign dir_ok = acc_i.direct;
    assign bank_ok = (acc_i.bank == `RCF_REG_BANK);
    assign addr_ok = (acc_i.addr == `RCF_REG_ADDR);

    // Direct addressing, bank 1, F2 only; indirect forms never match
    assign hit = dir_ok && bank_ok && addr_ok;
    assign wr_hit = acc_i.wr && hit;
    assign rd_hit = acc_i.rd && hit;

    // Event to bit position map; unused positions never set
    always_comb begin
        set_vec = 8'h00;
        set_vec[`RCF_BIT_WDT] = evt_i.watchdog_timer;
        set_vec[`RCF_BIT_PIN] = evt_i.external_reset_pin;
        set_vec[`RCF_BIT_LVR] = evt_i.low_voltage_reset;
    end

    // Per bit next value; events beat a same cycle software clear
    // so a reset that lands during a clear is never lost
    for (genvar gi = 0; gi < 8; gi++) begin : g_bit
        assign next_flags[gi] =
            (LIVE_MASK[gi] == 1'b0) ? 1'b0 :
            evt_i.low_voltage_reset ?
                ((gi == `RCF_BIT_LVR) ? 1'b1 : 1'b0) :
            set_vec[gi] ? 1'b1 :
            wr_hit ? (flags[gi] & acc_i.wdata[gi]) :
            flags[gi];
    end

    // Flags deliberately skip rst_i: they must survive the resets they record
    always_ff @(posedge core_clk_i) begin
        flags <= next_flags;
    end

    // Read data registered; stands one cycle, zero between reads
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= `RCF_RDATA_RST;
        end else if (rd_hit) begin
            rdata_o <= flags & LIVE_MASK;
        end else begin
            rdata_o <= `RCF_RDATA_RST;
        end
    end

    // Validity follows the option byte; flags are still recorded
    // because software may read them before trusting the option
    assign lvr_flag_valid_o = boot_opt_i[`RCF_OPT_LVR_EN];
    assign pin_flag_valid_o = boot_opt_i[`RCF_OPT_PIN_RST];

    // Low voltage reset leaves only its own flag standing
    property p_lvr_set;
        @(posedge core_clk_i)
        evt_i.low_voltage_reset |=> flags == `RCF_LVR_ONLY;
    endproperty
    a_lvr_set: assert property (p_lvr_set)
        else $error("low voltage reset did not leave flags at 02");

    // Watchdog reset sets its flag, low voltage flag untouched
    property p_wdt_set;
        @(posedge core_clk_i)
        evt_i.watchdog_timer && !evt_i.low_voltage_reset |=>
        flags[`RCF_BIT_WDT] &&
        flags[`RCF_BIT_LVR] == $past(flags[`RCF_BIT_LVR]);
    endproperty
    a_wdt_set: assert property (p_wdt_set)
        else $error("watchdog reset flag wrong");

    // Pin reset sets its flag, low voltage flag untouched
    property p_pin_set;
        @(posedge core_clk_i)
        evt_i.external_reset_pin && !evt_i.low_voltage_reset |=>
        flags[`RCF_BIT_PIN] &&
        flags[`RCF_BIT_LVR] == $past(flags[`RCF_BIT_LVR]);
    endproperty
    a_pin_set: assert property (p_pin_set)
        else $error("pin reset flag wrong");

    // Watchdog alone must not disturb the pin flag
    property p_wdt_keep_pin;
        @(posedge core_clk_i)
        evt_i.watchdog_timer && !evt_i.external_reset_pin &&
        !evt_i.low_voltage_reset && !wr_hit |=>
        flags[`RCF_BIT_PIN] == $past(flags[`RCF_BIT_PIN]);
    endproperty
    a_wdt_keep_pin: assert property (p_wdt_keep_pin)
        else $error("watchdog reset changed pin flag");

    // Pin alone must not disturb the watchdog flag
    property p_pin_keep_wdt;
        @(posedge core_clk_i)
        evt_i.external_reset_pin && !evt_i.watchdog_timer &&
        !evt_i.low_voltage_reset && !wr_hit |=>
        flags[`RCF_BIT_WDT] == $past(flags[`RCF_BIT_WDT]);
    endproperty
    a_pin_keep_wdt: assert property (p_pin_keep_wdt)
        else $error("pin reset changed watchdog flag");

    // Without an event no flag can rise, whatever software writes
    property p_no_sw_set;
        @(posedge core_clk_i)
        !(|evt_i) |=> (flags & ~$past(flags)) == 8'h00;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("flag set without a reset event");

    // A hit write clears exactly the bits written as 0
    property p_clear;
        @(posedge core_clk_i)
        wr_hit && !(|evt_i) |=>
        flags == ($past(flags) & $past(acc_i.wdata));
    endproperty
    a_clear: assert property (p_clear)
        else $error("write did not clear flags");

    // A write that misses the register changes nothing
    property p_write_miss;
        @(posedge core_clk_i)
        acc_i.wr && !hit && !(|evt_i) |=> flags == $past(flags);
    endproperty
    a_write_miss: assert property (p_write_miss)
        else $error("missed write changed flags");

    // A write to the right address in bank 0 is ignored
    property p_bank_miss;
        @(posedge core_clk_i)
        acc_i.wr && dir_ok && addr_ok && !bank_ok && !(|evt_i) |=>
        flags == $past(flags);
    endproperty
    a_bank_miss: assert property (p_bank_miss)
        else $error("bank 0 write changed flags");

    // Unused positions never hold a one
    property p_unused;
        @(posedge core_clk_i)
        (flags & ~LIVE_MASK) == 8'h00;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused flag bit set");

    // The core reset leaves the recorded flags alone
    property p_rst_keep;
        @(posedge core_clk_i)
        rst_i && !(|evt_i) && !wr_hit |=> flags == $past(flags);
    endproperty
    a_rst_keep: assert property (p_rst_keep)
        else $error("core reset changed flags");

    // Reads outside direct F2 bank 1 return zero
    property p_indirect;
        @(posedge core_clk_i) disable iff (rst_i)
        acc_i.rd && !hit |=> rdata_o == 8'h00;
    endproperty
    a_indirect: assert property (p_indirect)
        else $error("read answered outside direct F2 bank 1");

    // Read data stands only in the cycle after a read
    property p_read_stands;
        @(posedge core_clk_i) disable iff (rst_i)
        !acc_i.rd |=> rdata_o == 8'h00;
    endproperty
    a_read_stands: assert property (p_read_stands)
        else $error("read data held without a read");

    // A hit read returns the flags of the read cycle
    property p_read;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_hit |=> rdata_o == $past(flags);
    endproperty
    a_read: assert property (p_read)
        else $error("read data wrong");
endmodule // rcf_flags
`default_nettype wire

//--- reset_cause_flags_test.sv
// Self-checking bench for the reset cause flag register
`timescale 1ns/10ps
`default_nettype none
module reset_cause_flags_test;
    import rcf_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    rcf_access_t acc_i = '0;
    rcf_events_t evt_i = '0;
    logic [7:0] boot_opt_i = 8'h84;
    logic [7:0] rdata_o;
    logic lvr_v, pin_v;
    int error_cnt = 0;
    int n_compared = 0;
    always #5 core_clk_i = ~core_clk_i;
    rcf_flags dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .acc_i(acc_i),
        .evt_i(evt_i), .boot_opt_i(boot_opt_i), .rdata_o(rdata_o),
        .lvr_flag_valid_o(lvr_v), .pin_flag_valid_o(pin_v));
    task automatic chk(string s, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    // One access cycle; read data lands one edge after the strobe
    task automatic bus(logic w, logic d, logic b, logic [7:0] a, v, e);
        @(posedge core_clk_i) acc_i <= '{w, !w, b, d, a, v};
        @(posedge core_clk_i) acc_i <= '0;
        #1 if (!w) chk("rdata", e, rdata_o);
    endtask
    task automatic ev(rcf_events_t x, logic [7:0] e);
        @(posedge core_clk_i) evt_i <= x;
        @(posedge core_clk_i) evt_i <= '0;
        bus(0, 1, 1, 8'hF2, 8'h00, e);
    endtask
    task automatic t_events();
        ev(3'h4, 8'h02);
        ev(3'h2, 8'h06);
        ev(3'h1, 8'h16);
        ev(3'h4, 8'h02);
        $display("events done");
    endtask
    task automatic t_writes();
        ev(3'h3, 8'h16);
        bus(1, 1, 1, 8'hF2, 8'hFF, 0);
        bus(0, 1, 1, 8'hF2, 0, 8'h16);
        bus(1, 1, 1, 8'hF2, 8'hEF, 0);
        bus(0, 1, 1, 8'hF2, 0, 8'h06);
        bus(1, 1, 0, 8'hF2, 8'h00, 0);
        bus(1, 0, 1, 8'hF2, 8'h00, 0);
        bus(1, 1, 1, 8'hF3, 8'h00, 0);
        bus(0, 1, 1, 8'hF2, 0, 8'h06);
        bus(0, 0, 1, 8'hF2, 0, 8'h00);
        bus(0, 1, 0, 8'hF2, 0, 8'h00);
        bus(1, 1, 1, 8'hF2, 8'h00, 0);
        bus(0, 1, 1, 8'hF2, 0, 8'h00);
        $display("writes done");
    endtask
    // Mid-run core reset: read data drops, flags survive
    task automatic t_reset();
        ev(3'h1, 8'h10);
        @(posedge core_clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 chk("rdata_rst", 8'h00, rdata_o);
        @(posedge core_clk_i) rst_i <= 1'b0;
        bus(0, 1, 1, 8'hF2, 0, 8'h10);
        $display("reset done");
    endtask
    task automatic t_valid();
        #1 chk("valid", 8'h03, {6'h00, lvr_v, pin_v});
        @(posedge core_clk_i) boot_opt_i <= 8'h7B;
        #1 chk("valid", 8'h00, {6'h00, lvr_v, pin_v});
        $display("validity done");
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_events();
        t_writes();
        t_reset();
        t_valid();
        end_sim();
    end
    // Tests need well under 100 cycles; allow ten times that
    initial begin
        #10000 error_cnt++;
        end_sim();
    end
endmodule // reset_cause_flags_test
`default_nettype wire
